// ===== logic/cmh_msg_handler.sv
// The address map and the APB register port were decided locally.
`include "cmh_regs.svh"

// Function
// - Extended filter code 001 stores in receive FIFO 0, 010 in FIFO 1.
// - Extended filter type 10: first field compare value, second field mask.
// - Zero mask bits are ignored; all-zero mask accepts every frame.
// - Standard filters support codes 001/010 and classic type 10 likewise.
// - Handler scans buffers continuously, keeping a three-entry pipeline of best messages.
// - Higher-priority new request is inserted ahead while an earlier frame transmits.
// - Lost arbitration or error: next entry takes over, failed one is requeued.
// - Queue-select bit 0: dedicated buffers and FIFO compete by bus priority.
// - Ones written to add-request mark buffers pending, several per write.
// - Equal identifiers requested together go out lowest buffer number first.
// - Finished frame raises complete flag and sets that buffer's occurred bit.
// - FIFO-empty flag sets when a FIFO frame completes and none remain.
// - Halt request or bus-off returns the debug machine to Idle.
// - Config unlock bit leaves the debug state field untouched.
// - In state 11 the DMA request holds until acknowledge, halt, bus-off or debug disable returns to Idle.
// - States 01 and 10 advance on further debug messages while not halted.
// - Without debug support enabled the debug machine stays Idle.
// - Error counter, exception, FD, rate-switch, ESI and error codes clear on read.
// - Acceptance by a filter with code 100, 101 or 110 sets high-priority flag.
module cmh_msg_handler import cmh_pkg::*; #(
   parameter int N_DED = 4,
   parameter int N_FIFO = 4
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input cmh_rx_frame_t rx_frame,
   output logic rx_store_fifo0,
   output logic rx_store_fifo1,
   output cmh_tx_req_t tx_req,
   input wire logic tx_done,
   input wire logic tx_fail,
   input cmh_pe_status_t pe_status,
   input wire logic bus_off,
   input wire logic dma_ack,
   output logic dma_req
);
   // Slot numbers travel in 4 bits, so N_DED + N_FIFO must stay at or below 16
   localparam int NS = N_DED + N_FIFO;
   localparam int SW = $clog2(NS);
   localparam int FW = $clog2(N_FIFO);

   logic [3:0] ctrl_reg;
   logic [2:0] ir_reg;
   logic [NS-1:0] pend_reg;
   logic [NS-1:0] pend_next;
   logic [NS-1:0] occ_reg;
   logic [SW-1:0] sel_reg;
   logic [26:0] sfilt_reg;
   logic [31:0] efilt0_reg;
   logic [31:0] efilt1_reg;
   logic [7:0] cel_reg;
   logic [3:0] psr_flags_reg;
   logic [2:0] lec_reg;
   logic [2:0] dlec_reg;
   logic [FW-1:0] get_reg;
   logic [FW-1:0] put_reg;
   cmh_pipe_ent_t pipe_reg [3];
   logic [SW-1:0] scan_ptr_reg;
   logic [SW-1:0] scan_slot_reg;
   logic scan_vld_reg;
   logic clean_reg;
   cmh_dms_t dms_reg;
   logic pslverr_reg;
   logic [31:0] rd_data;
   logic rd_hit;
   logic setup;
   logic access;
   logic wr;
   logic halt;
   logic qmode;
   logic fifo_full;
   logic [NS-1:0] done_mask;
   logic [NS-1:0] ded_set;
   logic [NS-1:0] fifo_set;
   logic fifo_done;
   logic mem_we;
   logic [SW-1:0] mem_waddr;
   logic [29:0] mem_rdata;
   logic elig;
   logic in_pipe;
   logic ins_ok;
   logic [29:0] cand_key;
   logic [3:0] cand_slot;
   logic std_ok;
   logic ext_ok;
   logic rx_hit;
   logic [2:0] fec;
   logic dbg_msg;
   logic clr_ecr;
   logic clr_psr;

   function automatic logic filt_hit(input logic [1:0] ft, input logic [28:0] id,
                                     input logic [28:0] a, input logic [28:0] b);
      logic r;
      case (ft)
         `CMH_FT_RANGE: r = (id >= a) && (id <= b);
         `CMH_FT_DUAL: r = (id == a) || (id == b);
         `CMH_FT_CLASSIC: r = ((id ^ a) & b) == '0;
         default: r = 1'b0;
      endcase
      return r;
   endfunction : filt_hit

   // Lower key wins; standard ids align with the base part of extended ids
   function automatic logic [29:0] arb_key(input logic ext, input logic [28:0] id);
      return ext ? {id, 1'b1} : {id[10:0], 18'h0_0000, 1'b0};
   endfunction : arb_key

   function automatic logic beats(input cmh_pipe_ent_t e, input logic [29:0] ck,
                                  input logic [3:0] cs);
      logic [29:0] ek;
      ek = arb_key(e.ext, e.id);
      return !e.valid || (ck < ek) || ((ck == ek) && (cs < e.slot));
   endfunction : beats

   function automatic logic [FW-1:0] wrap_inc(input logic [FW-1:0] v);
      return (v == FW'(N_FIFO - 1)) ? '0 : v + FW'(1);
   endfunction : wrap_inc

   assign setup = psel & ~penable;
   assign access = psel & penable;
   assign wr = access & pwrite;
   assign pready = access;
   assign pslverr = pslverr_reg;
   assign halt = ctrl_reg[`CMH_CTRL_HALT];
   assign qmode = ctrl_reg[`CMH_CTRL_QMODE];
   assign clr_ecr = setup & ~pwrite & (paddr == `CMH_OFF_ECR);
   assign clr_psr = setup & ~pwrite & (paddr == `CMH_OFF_PSR);

   // Read data is captured in the setup cycle so prdata comes from a flop
   always_comb begin
      rd_data = '0;
      rd_hit = 1'b1;
      case (paddr)
         `CMH_OFF_CTRL: rd_data = 32'(ctrl_reg);
         `CMH_OFF_STAT: rd_data = 32'({tx_req.req, fifo_full, dms_reg});
         `CMH_OFF_IR: rd_data = 32'(ir_reg);
         `CMH_OFF_TX_BUFFER_ADD_REQUEST: rd_data = 32'(pend_reg);
         `CMH_OFF_TX_OCCURRED_FLAGS: rd_data = 32'(occ_reg);
         `CMH_OFF_TXSEL: rd_data = 32'(sel_reg);
         `CMH_OFF_TXID, `CMH_OFF_FIFO: rd_data = '0;
         `CMH_OFF_SFILT: rd_data = 32'(sfilt_reg);
         `CMH_OFF_EFILT0: rd_data = efilt0_reg;
         `CMH_OFF_EFILT1: rd_data = efilt1_reg;
         `CMH_OFF_ECR: rd_data = 32'(cel_reg);
         `CMH_OFF_PSR: rd_data = 32'({psr_flags_reg, dlec_reg, 5'h00, lec_reg});
         default: rd_hit = 1'b0;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= '0;
         pslverr_reg <= 1'b0;
      end else if (setup) begin
         prdata <= pwrite ? '0 : rd_data;
         pslverr_reg <= ~rd_hit;
      end
   end

   // The unlock bit only gates filter writes; it never touches the debug state
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_reg <= `CMH_CTRL_RST;
         sel_reg <= '0;
      end else if (wr) begin
         if (paddr == `CMH_OFF_CTRL) begin
            ctrl_reg <= pwdata[`CMH_CTRL_W];
         end
         if (paddr == `CMH_OFF_TXSEL) begin
            sel_reg <= pwdata[SW-1:0];
         end
      end
   end

   // Filters only change while halted and unlocked; halt does not stop reception, so a frame can see half an update
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sfilt_reg <= '0;
         efilt0_reg <= '0;
         efilt1_reg <= '0;
      end else if (wr && halt && ctrl_reg[`CMH_CTRL_UNLOCK]) begin
         if (paddr == `CMH_OFF_SFILT) begin
            sfilt_reg <= pwdata[26:0];
         end
         if (paddr == `CMH_OFF_EFILT0) begin
            efilt0_reg <= pwdata;
         end
         if (paddr == `CMH_OFF_EFILT1) begin
            efilt1_reg <= pwdata;
         end
      end
   end

   // Acceptance filtering, one standard and one extended element
   always_comb begin
      std_ok = filt_hit(sfilt_reg[`CMH_SF_FT], 29'(rx_frame.id[10:0]),
                        29'(sfilt_reg[`CMH_SF_CMP]), 29'(sfilt_reg[`CMH_SF_MSK]));
      ext_ok = filt_hit(efilt1_reg[`CMH_EF_FT], rx_frame.id,
                        efilt0_reg[`CMH_EF_ID], efilt1_reg[`CMH_EF_ID]);
      fec = rx_frame.ext ? efilt0_reg[`CMH_EF_FEC] : sfilt_reg[`CMH_SF_FEC];
      rx_hit = rx_frame.valid & (rx_frame.ext ? ext_ok : std_ok);
      dbg_msg = rx_hit & (fec == `CMH_FEC_DEBUG);
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rx_store_fifo0 <= 1'b0;
         rx_store_fifo1 <= 1'b0;
      end else begin
         rx_store_fifo0 <= rx_hit & ((fec == `CMH_FEC_FIFO0) | (fec == `CMH_FEC_PRIO_F0));
         rx_store_fifo1 <= rx_hit & ((fec == `CMH_FEC_FIFO1) | (fec == `CMH_FEC_PRIO_F1));
      end
   end

   // Transmit buffer identifiers; FIFO elements sit above the dedicated buffers
   assign fifo_full = pend_reg[N_DED + int'(put_reg)];
   assign mem_we = wr & ((paddr == `CMH_OFF_TXID) | ((paddr == `CMH_OFF_FIFO) & ~fifo_full));
   assign mem_waddr = (paddr == `CMH_OFF_FIFO) ? SW'(N_DED) + SW'(put_reg) : sel_reg;

   cmh_id_ram #(.W(30), .D(NS)) u_id_ram (
      .pclk(pclk),
      .presetn(presetn),
      .wr_en(mem_we),
      .wr_addr(mem_waddr),
      .wr_data(pwdata[`CMH_TXID_W]),
      .rd_addr(scan_ptr_reg),
      .rd_data(mem_rdata)
   );

   always_comb begin
      done_mask = '0;
      if (tx_done && pipe_reg[0].valid) begin
         done_mask = NS'(1) << pipe_reg[0].slot;
      end
      ded_set = '0;
      if (wr && (paddr == `CMH_OFF_TX_BUFFER_ADD_REQUEST)) begin
         ded_set = NS'(pwdata[N_DED-1:0]);
      end
      fifo_set = '0;
      if (wr && (paddr == `CMH_OFF_FIFO) && !fifo_full) begin
         fifo_set = NS'(1) << (N_DED + int'(put_reg));
      end
      pend_next = (pend_reg & ~done_mask) | ded_set | fifo_set;
      fifo_done = done_mask[NS-1:N_DED] != '0;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pend_reg <= '0;
         occ_reg <= '0;
      end else begin
         pend_reg <= pend_next;
         occ_reg <= (occ_reg & ~(ded_set | fifo_set)) | done_mask;
      end
   end

   // Queue mode frees slots out of order, so a push may wait on a busy put slot
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         put_reg <= '0;
         get_reg <= '0;
      end else begin
         if (fifo_set != '0) begin
            put_reg <= wrap_inc(put_reg);
         end
         if (fifo_done && !qmode) begin
            get_reg <= wrap_inc(get_reg);
         end
      end
   end

   // Set wins over the write-one-to-clear of the same cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ir_reg <= '0;
      end else begin
         ir_reg <= (ir_reg & ~((wr && (paddr == `CMH_OFF_IR)) ? pwdata[`CMH_IR_W] : 3'h0))
                   | {rx_hit & fec[2] & (fec != `CMH_FEC_DEBUG),
                      fifo_done & (pend_next[NS-1:N_DED] == '0),
                      done_mask != '0};
      end
   end

   // Scanner walks all slots, one per cycle, memory data one cycle behind
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         scan_ptr_reg <= '0;
         scan_slot_reg <= '0;
         scan_vld_reg <= 1'b0;
         clean_reg <= 1'b0;
      end else begin
         scan_ptr_reg <= (scan_ptr_reg == SW'(NS - 1)) ? '0 : scan_ptr_reg + SW'(1);
         scan_slot_reg <= scan_ptr_reg;
         scan_vld_reg <= 1'b1;
         clean_reg <= ~|(ded_set | fifo_set) & (clean_reg | (scan_slot_reg == '0));
      end
   end

   // Outside queue mode only the FIFO head competes, which keeps FIFO write order on the bus
   always_comb begin
      cand_slot = 4'(scan_slot_reg);
      cand_key = arb_key(mem_rdata[`CMH_TXID_EXT], mem_rdata[28:0]);
      elig = pend_reg[scan_slot_reg]
             & ((int'(scan_slot_reg) < N_DED) | qmode
                | (scan_slot_reg == SW'(N_DED) + SW'(get_reg)));
      in_pipe = 1'b0;
      for (int i = 0; i < 3; i++) begin
         in_pipe = in_pipe | (pipe_reg[i].valid & (pipe_reg[i].slot == cand_slot));
      end
      ins_ok = scan_vld_reg & elig & ~in_pipe & ~tx_done & ~tx_fail;
   end

   // Entry 0 loads after a whole pass with no new request, so ties keep buffer order
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int i = 0; i < 3; i++) begin
            pipe_reg[i] <= '0;
         end
      end else if ((tx_done || tx_fail) && pipe_reg[0].valid) begin
         pipe_reg[0] <= pipe_reg[1];
         pipe_reg[1] <= pipe_reg[2];
         pipe_reg[2] <= '0;
      end else if (ins_ok && beats(pipe_reg[1], cand_key, cand_slot)) begin
         pipe_reg[1] <= {1'b1, cand_slot, mem_rdata};
         pipe_reg[2] <= pipe_reg[1];
      end else if (ins_ok && beats(pipe_reg[2], cand_key, cand_slot)) begin
         pipe_reg[2] <= {1'b1, cand_slot, mem_rdata};
      end else if (!pipe_reg[0].valid && clean_reg && scan_slot_reg == SW'(NS - 1)) begin
         pipe_reg[0] <= pipe_reg[1];
         pipe_reg[1] <= pipe_reg[2];
         pipe_reg[2] <= '0;
      end
   end

   // A failed slot stays pending, so the scanner requeues it by priority
   assign tx_req.req = pipe_reg[0].valid & ~halt;
   assign tx_req.ext = pipe_reg[0].ext;
   assign tx_req.id = pipe_reg[0].id;

   // Debug message machine
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         dms_reg <= CMH_DMS_IDLE;
      end else if (!ctrl_reg[`CMH_CTRL_DBGEN]) begin
         dms_reg <= CMH_DMS_IDLE;
      end else if (halt || bus_off) begin
         dms_reg <= CMH_DMS_IDLE;
      end else begin
         case (dms_reg)
            CMH_DMS_IDLE: if (dbg_msg) dms_reg <= CMH_DMS_GOT_A;
            CMH_DMS_GOT_A: if (dbg_msg) dms_reg <= CMH_DMS_GOT_AB;
            CMH_DMS_GOT_AB: if (dbg_msg) dms_reg <= CMH_DMS_DMA_WAIT;
            CMH_DMS_DMA_WAIT: if (dma_ack) dms_reg <= CMH_DMS_IDLE;
            default: dms_reg <= CMH_DMS_IDLE;
         endcase
      end
   end

   assign dma_req = dms_reg == CMH_DMS_DMA_WAIT;

   // Read clears at the setup edge, the same edge that captures prdata
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cel_reg <= '0;
      end else if (pe_status.cel_inc) begin
         cel_reg <= clr_ecr ? 8'h01 : (cel_reg == `CMH_CEL_MAX) ? cel_reg : cel_reg + 8'h01;
      end else if (clr_ecr) begin
         cel_reg <= '0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         psr_flags_reg <= '0;
         lec_reg <= `CMH_LEC_NONE;
         dlec_reg <= `CMH_LEC_NONE;
      end else begin
         psr_flags_reg <= (clr_psr ? 4'h0 : psr_flags_reg)
                          | {pe_status.pxe, pe_status.rfdf, pe_status.rbrs, pe_status.resi};
         if (pe_status.lec != `CMH_LEC_NONE) begin
            lec_reg <= pe_status.lec;
         end else if (clr_psr) begin
            lec_reg <= `CMH_LEC_NONE;
         end
         if (pe_status.dlec != `CMH_LEC_NONE) begin
            dlec_reg <= pe_status.dlec;
         end else if (clr_psr) begin
            dlec_reg <= `CMH_LEC_NONE;
         end
      end
   end
endmodule : cmh_msg_handler

// ===== logic/cmh_regs.svh
`ifndef CMH_REGS_SVH
`define CMH_REGS_SVH

// Register byte addresses
`define CMH_OFF_CTRL 12'h000
`define CMH_OFF_STAT 12'h004
`define CMH_OFF_IR 12'h008
`define CMH_OFF_TX_BUFFER_ADD_REQUEST 12'h00C
`define CMH_OFF_TX_OCCURRED_FLAGS 12'h010
`define CMH_OFF_TXSEL 12'h014
`define CMH_OFF_TXID 12'h018
`define CMH_OFF_FIFO 12'h01C
`define CMH_OFF_SFILT 12'h020
`define CMH_OFF_EFILT0 12'h024
`define CMH_OFF_EFILT1 12'h028
`define CMH_OFF_ECR 12'h02C
`define CMH_OFF_PSR 12'h030

// Control register
`define CMH_CTRL_RST 4'h1
`define CMH_CTRL_HALT 0
`define CMH_CTRL_UNLOCK 1
`define CMH_CTRL_QMODE 2
`define CMH_CTRL_DBGEN 3
`define CMH_CTRL_W 3:0

// Flag register
`define CMH_TX_COMPLETE_FLAG 0
`define CMH_TX_FIFO_EMPTY_FLAG 1
`define CMH_HIGH_PRIORITY_MSG_FLAG 2
`define CMH_IR_W 2:0

// Filter element fields
`define CMH_SF_CMP 10:0
`define CMH_SF_MSK 21:11
`define CMH_SF_FT 23:22
`define CMH_SF_FEC 26:24
`define CMH_EF_ID 28:0
`define CMH_EF_FEC 31:29
`define CMH_EF_FT 31:30

// Filter configuration codes
`define CMH_FEC_DIS 3'h0
`define CMH_FEC_FIFO0 3'h1
`define CMH_FEC_FIFO1 3'h2
`define CMH_FEC_REJECT 3'h3
`define CMH_FEC_PRIO 3'h4
`define CMH_FEC_PRIO_F0 3'h5
`define CMH_FEC_PRIO_F1 3'h6
`define CMH_FEC_DEBUG 3'h7

// Filter types
`define CMH_FT_RANGE 2'h0
`define CMH_FT_DUAL 2'h1
`define CMH_FT_CLASSIC 2'h2

// Transmit identifier word
`define CMH_TXID_EXT 29
`define CMH_TXID_W 29:0

`define CMH_CEL_MAX 8'hFF
`define CMH_LEC_NONE 3'h0

`endif

// ===== logic/cmh_pkg.sv
package cmh_pkg;
   typedef enum logic [1:0] {
      CMH_DMS_IDLE,
      CMH_DMS_GOT_A,
      CMH_DMS_GOT_AB,
      CMH_DMS_DMA_WAIT
   } cmh_dms_t;

   typedef struct packed {
      logic valid;
      logic ext;
      logic [28:0] id;
   } cmh_rx_frame_t;

   typedef struct packed {
      logic req;
      logic ext;
      logic [28:0] id;
   } cmh_tx_req_t;

   typedef struct packed {
      logic [2:0] lec;
      logic [2:0] dlec;
      logic pxe;
      logic rfdf;
      logic rbrs;
      logic resi;
      logic cel_inc;
   } cmh_pe_status_t;

   typedef struct packed {
      logic valid;
      logic [3:0] slot;
      logic ext;
      logic [28:0] id;
   } cmh_pipe_ent_t;
endpackage : cmh_pkg

// ===== logic/cmh_id_ram.sv
module cmh_id_ram #(
   parameter int W = 30,
   parameter int D = 8
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic wr_en,
   input wire logic [$clog2(D)-1:0] wr_addr,
   input wire logic [W-1:0] wr_data,
   input wire logic [$clog2(D)-1:0] rd_addr,
   output logic [W-1:0] rd_data
);
   logic [W-1:0] mem [D];

   // No reset on the array: contents are valid only once written
   always_ff @(posedge pclk) begin
      if (wr_en) begin
         mem[wr_addr] <= wr_data;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rd_data <= '0;
      end else begin
         rd_data <= mem[rd_addr];
      end
   end
endmodule : cmh_id_ram

// ===== tb/cmh_msg_handler_props.sv
`include "cmh_regs.svh"
module cmh_msg_handler_props import cmh_pkg::*; #(
   parameter int N_DED = 4,
   parameter int N_FIFO = 4
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input cmh_rx_frame_t rx_frame,
   input wire logic rx_store_fifo0,
   input wire logic rx_store_fifo1,
   input cmh_tx_req_t tx_req,
   input wire logic tx_done,
   input wire logic tx_fail,
   input wire logic bus_off,
   input wire logic dma_ack,
   input wire logic dma_req
);
   logic ctrl_wr;
   // Control writes may halt or stop debug
   assign ctrl_wr = psel && penable && pwrite && paddr == `CMH_OFF_CTRL;
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence halt_wr;
      ctrl_wr && pwdata[`CMH_CTRL_HALT];
   endsequence
   sequence dma_release;
      dma_req && dma_ack;
   endsequence
   dma_hold_a: assert property (dma_req && !dma_ack && !bus_off && !ctrl_wr
      && !$past(ctrl_wr) |=> dma_req)
      else $error("dma request dropped without acknowledge");
   dma_release_a: assert property (dma_release |=> !dma_req)
      else $error("dma request kept after acknowledge");
   busoff_idle_a: assert property (bus_off |=> !dma_req)
      else $error("dma request kept in bus-off");
   halt_idle_a: assert property (halt_wr |=> !tx_req.req ##1 !dma_req)
      else $error("halt write left request active");
   dma_cause_a: assert property ($rose(dma_req) |-> $past(rx_frame.valid))
      else $error("dma request rose without a frame");
   rx_single_a: assert property (rx_frame.valid |=> !(rx_store_fifo0 && rx_store_fifo1))
      else $error("frame stored in both fifos");
   rx_cause_a: assert property (rx_store_fifo0 || rx_store_fifo1 |-> $past(rx_frame.valid))
      else $error("store strobe without a frame");
   tx_hold_a: assert property (tx_req.req && !tx_done && !tx_fail && !bus_off
      && !ctrl_wr |=> $stable(tx_req))
      else $error("active transmit changed mid frame");
endmodule : cmh_msg_handler_props

bind cmh_msg_handler cmh_msg_handler_props #(.N_DED(N_DED), .N_FIFO(N_FIFO)) i_props (
   .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .rx_frame, .rx_store_fifo0,
   .rx_store_fifo1, .tx_req, .tx_done, .tx_fail, .bus_off, .dma_ack, .dma_req);

// ===== tb/cmh_can_node.sv
module cmh_can_node import cmh_pkg::*; (
   input wire logic pclk,
   input wire logic presetn,
   input cmh_tx_req_t tx_req,
   input wire logic fail_next,
   input wire logic [7:0] slow,
   output logic tx_done,
   output logic tx_fail
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [29:0] sent_q[$];
   int cnt;
   // A frame, or a failed attempt, lasts slow+1 cycles
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tx_done <= 1'b0;
         tx_fail <= 1'b0;
         cnt <= 0;
      end else begin
         tx_done <= 1'b0;
         tx_fail <= 1'b0;
         if (tx_done) begin
            sent_q.push_back({tx_req.ext, tx_req.id});
         end
         if (tx_done || tx_fail || !tx_req.req) begin
            cnt <= 0;
         end else if (cnt == int'(slow)) begin
            tx_done <= !fail_next;
            tx_fail <= fail_next;
         end else begin
            cnt <= cnt + 1;
         end
      end
   end
endmodule : cmh_can_node

// ===== tb/test_can_msg_handler_filters_debug.sv
`include "cmh_regs.svh"
module test_can_msg_handler_filters_debug import cmh_pkg::*;;
   timeunit 1ns;
   timeprecision 1ns;
   logic pclk;
   logic presetn;
   logic psel;
   logic penable;
   logic pwrite;
   logic [11:0] paddr;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   cmh_rx_frame_t rx_frame;
   logic rx_store_fifo0;
   logic rx_store_fifo1;
   cmh_tx_req_t tx_req;
   logic tx_done;
   logic tx_fail;
   cmh_pe_status_t pe_status;
   logic bus_off;
   logic dma_ack;
   logic dma_req;
   logic fail_next;
   logic [7:0] slow;
   logic [31:0] rd;
   logic err;
   int errors;
   int n_checks;

   cmh_msg_handler i_cmh_msg_handler (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
      .pwdata, .prdata, .pready, .pslverr, .rx_frame, .rx_store_fifo0, .rx_store_fifo1,
      .tx_req, .tx_done, .tx_fail, .pe_status, .bus_off, .dma_ack, .dma_req);
   cmh_can_node i_cmh_can_node (.pclk, .presetn, .tx_req, .fail_next, .slow, .tx_done,
      .tx_fail);

   always #50 pclk = ~pclk; // Free running, never gated

   task automatic give_verdict;
      $display("checks=%0d errors=%0d", n_checks, errors);
      if (errors == 0 && n_checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : give_verdict

   task automatic timeout;
      errors++;
      give_verdict();
   endtask : timeout

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         errors++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int k;
      k = 0;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) begin
         k++;
         if (k > 16) timeout();
         @(posedge pclk);
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask : wr

   task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0000_0000);
      chk(rd, exp);
   endtask : rdc

   // Halt and unlock around two filter words at a and a+4
   task automatic cfg(input logic [11:0] a, input logic [31:0] d, input logic [31:0] d1);
      wr(`CMH_OFF_CTRL, 32'h0000_0003);
      wr(a, d);
      wr(a + 12'h004, d1);
      wr(`CMH_OFF_CTRL, 32'h0000_0000);
   endtask : cfg

   // exp 11 skips the store check (debug frames)
   task automatic rx(input logic ext, input logic [28:0] id, input logic [1:0] exp);
      @(posedge pclk);
      rx_frame <= '{valid: 1'b1, ext: ext, id: id};
      @(posedge pclk);
      rx_frame.valid <= 1'b0;
      #1;
      if (exp != 2'b11) chk({30'h0, rx_store_fifo1, rx_store_fifo0}, {30'h0, exp});
   endtask : rx

   task automatic wait_sent(input int n);
      int k;
      k = 0;
      while (i_cmh_can_node.sent_q.size() < n) begin
         k++;
         if (k > 500) timeout();
         @(posedge pclk);
      end
   endtask : wait_sent

   task automatic t_reset;
      rdc(`CMH_OFF_CTRL, 32'h0000_0001);
      apb(1'b0, 12'hFFC, 32'h0000_0000);
      chk({31'h0, err}, 32'h0000_0001);
   endtask : t_reset

   task automatic t_filters;
      logic [2:0] codes [4];
      codes = '{3'h1, 3'h2, 3'h5, 3'h6};
      foreach (codes[i]) begin
         cfg(`CMH_OFF_EFILT0, {codes[i], 29'h0000_0000}, 32'h8000_0000);
         rx(1'b1, 29'h1ABC_DEF0 + 29'(i), codes[i][1:0]);
         rdc(`CMH_OFF_IR, {29'h0, codes[i][2], 2'b00});
         wr(`CMH_OFF_IR, 32'h0000_0007);
      end
      cfg(`CMH_OFF_EFILT0, 32'h2123_4567, 32'h9FFF_FFFF);
      rx(1'b1, 29'h0123_4567, 2'b01);
      rx(1'b1, 29'h0123_4566, 2'b00);
      cfg(`CMH_OFF_EFILT0, 32'h2123_4567, 32'h9FFF_FF00);
      rx(1'b1, 29'h0123_45AA, 2'b01);
      cfg(`CMH_OFF_SFILT, 32'h0280_0123, 32'h0000_0000);
      rx(1'b0, 29'h0000_0555, 2'b10);
      cfg(`CMH_OFF_SFILT, 32'h0180_0123, 32'h0000_0000);
      rx(1'b0, 29'h0000_0555, 2'b01);
   endtask : t_filters

   task automatic t_psr;
      @(posedge pclk);
      pe_status <= '{lec: 3'h3, dlec: 3'h5, pxe: 1'b1, rfdf: 1'b1, rbrs: 1'b1, resi: 1'b1,
         cel_inc: 1'b1};
      @(posedge pclk);
      pe_status <= '0;
      rdc(`CMH_OFF_PSR, 32'h0000_7D03);
      rdc(`CMH_OFF_PSR, 32'h0000_0000);
      rdc(`CMH_OFF_ECR, 32'h0000_0001);
      rdc(`CMH_OFF_ECR, 32'h0000_0000);
   endtask : t_psr

   task automatic t_debug;
      cfg(`CMH_OFF_EFILT0, 32'hE000_0000, 32'h8000_0000);
      wr(`CMH_OFF_CTRL, 32'h0000_0008);
      for (int s = 1; s <= 3; s++) begin
         rx(1'b1, 29'h0000_0042, 2'b11);
         rdc(`CMH_OFF_STAT, 32'(s));
      end
      chk({31'h0, dma_req}, 32'h0000_0001);
      wr(`CMH_OFF_CTRL, 32'h0000_000A);
      rdc(`CMH_OFF_STAT, 32'h0000_0003);
      chk({31'h0, dma_req}, 32'h0000_0001);
      @(posedge pclk);
      dma_ack <= 1'b1;
      @(posedge pclk);
      dma_ack <= 1'b0;
      #1;
      chk({31'h0, dma_req}, 32'h0000_0000);
      rx(1'b1, 29'h0000_0042, 2'b11);
      @(posedge pclk);
      bus_off <= 1'b1;
      @(posedge pclk);
      bus_off <= 1'b0;
      rdc(`CMH_OFF_STAT, 32'h0000_0000);
      rx(1'b1, 29'h0000_0042, 2'b11);
      wr(`CMH_OFF_CTRL, 32'h0000_0009);
      rdc(`CMH_OFF_STAT, 32'h0000_0000);
      wr(`CMH_OFF_CTRL, 32'h0000_0000);
      rx(1'b1, 29'h0000_0042, 2'b11);
      rdc(`CMH_OFF_STAT, 32'h0000_0000);
   endtask : t_debug

   task automatic t_tx;
      int k;
      k = 0;
      wr(`CMH_OFF_FIFO, 32'h2000_0500);
      wr(`CMH_OFF_FIFO, 32'h2000_0501);
      while (!(tx_req.req === 1'b1 && tx_req.id === 29'h0000_0500)) begin
         k++;
         if (k > 200) timeout();
         @(posedge pclk);
      end
      // Higher priority buffer arrives while the first fifo frame is on the wire
      wr(`CMH_OFF_TXSEL, 32'h0000_0002);
      wr(`CMH_OFF_TXID, 32'h2000_0100);
      wr(`CMH_OFF_TX_BUFFER_ADD_REQUEST, 32'h0000_0004);
      fail_next <= 1'b1;
      while (tx_fail !== 1'b1) begin
         k++;
         if (k > 400) timeout();
         @(posedge pclk);
      end
      fail_next <= 1'b0;
      wait_sent(3);
      chk(32'(i_cmh_can_node.sent_q[0]), 32'h2000_0100);
      chk(32'(i_cmh_can_node.sent_q[1]), 32'h2000_0500);
      chk(32'(i_cmh_can_node.sent_q[2]), 32'h2000_0501);
      rdc(`CMH_OFF_TX_OCCURRED_FLAGS, 32'h0000_0034);
      rdc(`CMH_OFF_IR, 32'h0000_0003);
      wr(`CMH_OFF_IR, 32'h0000_0007);
      wr(`CMH_OFF_TXSEL, 32'h0000_0000);
      wr(`CMH_OFF_TXID, 32'h2000_0200);
      wr(`CMH_OFF_TXSEL, 32'h0000_0001);
      wr(`CMH_OFF_TXID, 32'h2000_0200);
      wr(`CMH_OFF_TX_BUFFER_ADD_REQUEST, 32'h0000_0003);
      wait_sent(4);
      rdc(`CMH_OFF_TX_OCCURRED_FLAGS, 32'h0000_0035);
      wait_sent(5);
      rdc(`CMH_OFF_TX_OCCURRED_FLAGS, 32'h0000_0037);
      rdc(`CMH_OFF_IR, 32'h0000_0001);
   endtask : t_tx

   initial begin
      pclk = 1'b0;
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0000_0000;
      rx_frame = '0;
      pe_status = '0;
      bus_off = 1'b0;
      dma_ack = 1'b0;
      fail_next = 1'b0;
      slow = 8'h28;
      errors = 0;
      n_checks = 0;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      t_reset();
      t_filters();
      t_psr();
      t_debug();
      t_tx();
      give_verdict();
   end
endmodule : test_can_msg_handler_filters_debug
